// file: rtl/usb_ep_pkg.sv
// Shared constants for the endpoint FIFO and interrupt register block
package usb_ep_pkg;
	localparam int NUM_EP = 7;
	localparam int EP_W = 3;
	// Register word indices (printed offsets are not all multiples of four: byte address is index * 4)
	localparam logic [7:0] IDX_IRQ_ENABLE = 8'hC2;
	localparam logic [7:0] IDX_FIFO_DATA = 8'hCF;
	localparam logic [7:0] IDX_FIFO_CLEAR = 8'hD5;
	localparam logic [7:0] IDX_RX_COUNT = 8'hE2;
	localparam logic [7:0] IDX_IRQ_FLAGS = 8'hF8;
	localparam logic [7:0] IDX_EP_SELECT = 8'hC7;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'hB0;
	localparam logic [7:0] IDX_IRQ_MASK = 8'hB1;
	localparam logic [7:0] RST_ENABLE = 8'h00;
	localparam logic [7:0] RST_CLEAR = 8'h00;
	localparam logic [7:0] RST_MASK = 8'h00;
	localparam logic [2:0] RST_SELECT = 3'h0;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Status register bit positions
	localparam int ST_EP_EVENT = 0;
	localparam int ST_OVERFLOW = 1;
	localparam int ST_UNDERFLOW = 2;
	localparam int ST_W = 3;
	typedef enum logic [1:0] {
		WR_IDLE = 2'b00,
		WR_RESP = 2'b01
	} wr_state_t;
	typedef enum logic [1:0] {
		RD_IDLE = 2'b00,
		RD_WAIT = 2'b01,
		RD_RESP = 2'b10
	} rd_state_t;
endpackage : usb_ep_pkg

// file: rtl/ep_fifo_mem.sv
// Small byte memory with registered read data, shared by all endpoint FIFOs
`timescale 1ns/1ps
module ep_fifo_mem #(
	parameter int DW = 8,
	parameter int AW = 9
) (
	// Clock
	input wire logic clk_i,
	// Write port
	input wire logic we_i,
	input wire logic [AW-1:0] waddr_i,
	input wire logic [DW-1:0] wdata_i,
	// Read port
	input wire logic [AW-1:0] raddr_i,
	output logic [DW-1:0] rdata_o
);
	logic [DW-1:0] mem [0:(1<<AW)-1];
	always_ff @(posedge clk_i) begin
		if (we_i) begin
			mem[waddr_i] <= wdata_i;
		end
		rdata_o <= mem[raddr_i];
	end
endmodule : ep_fifo_mem

// file: rtl/usb_ep_regs.sv
// Endpoint FIFO data port, byte count, FIFO clear and interrupt registers on AXI4-Lite
//
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/1ps
// What this block does
// R1 - A data port write pushes a byte into the selected endpoint FIFO and a read pops the next.
// R2 - The data port has no defined content after reset, so an early read returns any value.
// R3 - The byte count register shows in seven bits the bytes received in the last packet.
// R4 - Bit 7 of byte count, FIFO clear, flag and enable registers reads zero and ignores writes.
// R5 - Each FIFO clear bit holds its endpoint FIFO empty while set and releases it when cleared.
// R6 - Firmware sets and clears each FIFO clear bit after any reset before using the endpoint.
// R7 - Flag bit n is set when endpoint n raises a status event while enable bit n is set.
// R8 - The flag register is read only; hardware clears its bits and software writes do nothing.
// R9 - Enable bit n lets interrupts from endpoint n through when set and blocks them when clear.
// R10 - An endpoint event is IN complete, OUT stored, SETUP received or STALL sent.
// R11 - Data port and byte count address the endpoint chosen by the select field; status is shared by all endpoints.
// R12 - One endpoint interrupt request is the OR of the seven flag bits.
module usb_ep_regs
	import usb_ep_pkg::*;
#(
	parameter int DEPTH_LOG2 = 6
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic usb_bus_reset_i,
	// AXI4-Lite write
	input wire logic [11:0] s_axi_awaddr_i,
	input wire logic s_axi_awvalid_i,
	output logic s_axi_awready_o,
	input wire logic [31:0] s_axi_wdata_i,
	input wire logic [3:0] s_axi_wstrb_i,
	input wire logic s_axi_wvalid_i,
	output logic s_axi_wready_o,
	output logic [1:0] s_axi_bresp_o,
	output logic s_axi_bvalid_o,
	input wire logic s_axi_bready_i,
	// AXI4-Lite read
	input wire logic [11:0] s_axi_araddr_i,
	input wire logic s_axi_arvalid_i,
	output logic s_axi_arready_o,
	output logic [31:0] s_axi_rdata_o,
	output logic [1:0] s_axi_rresp_o,
	output logic s_axi_rvalid_o,
	input wire logic s_axi_rready_i,
	// Serial engine side
	input wire logic [NUM_EP-1:0] sie_in_done_i,
	input wire logic [NUM_EP-1:0] sie_out_stored_i,
	input wire logic [NUM_EP-1:0] sie_setup_rx_i,
	input wire logic [NUM_EP-1:0] sie_stall_sent_i,
	input wire logic sie_wr_i,
	input wire logic [EP_W-1:0] sie_ep_i,
	input wire logic [7:0] sie_byte_i,
	input wire logic sie_pkt_start_i,
	input wire logic sie_rd_i,
	output logic [7:0] sie_byte_o,
	output logic [NUM_EP-1:0] fifo_clear_o,
	// Interrupts
	output logic ep_irq_o,
	output logic irq_o
);
	localparam int AW = EP_W + DEPTH_LOG2;
	typedef logic [DEPTH_LOG2:0] ptr_t;
	function automatic logic [7:0] word_idx(input logic [11:0] a);
		word_idx = a[9:2];
	endfunction : word_idx
	default clocking cb_chk @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);
	////////////////////////////////////////////////////////////////////////////
	// Register state
	logic [NUM_EP-1:0] irq_allow_r, irq_allow_nxt;
	logic [NUM_EP-1:0] fifo_clear_r, fifo_clear_nxt;
	logic [NUM_EP-1:0] irq_flag_r, irq_flag_nxt;
	logic [EP_W-1:0] selected_endpoint_r, selected_endpoint_nxt;
	logic [ST_W-1:0] status_r, status_nxt, mask_r, mask_nxt;
	logic [6:0] rx_byte_total_r [NUM_EP];
	ptr_t wptr_r [NUM_EP];
	ptr_t rptr_r [NUM_EP];
	wr_state_t wr_st_r, wr_st_nxt;
	rd_state_t rd_st_r, rd_st_nxt;
	logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
	logic [7:0] rd_idx_r, rd_idx_nxt;
	logic [31:0] rdata_r, rdata_nxt;
	////////////////////////////////////////////////////////////////////////////
	// Bus handshakes
	logic wr_go, rd_go;
	logic [7:0] wr_idx, wbyte;
	assign wr_go = (wr_st_r == WR_IDLE) && s_axi_awvalid_i && s_axi_wvalid_i;
	assign rd_go = (rd_st_r == RD_IDLE) && s_axi_arvalid_i;
	assign wr_idx = word_idx(s_axi_awaddr_i);
	assign wbyte = s_axi_wdata_i[7:0];
	assign s_axi_awready_o = wr_go;
	assign s_axi_wready_o = wr_go;
	assign s_axi_arready_o = rd_go;
	assign s_axi_bvalid_o = (wr_st_r == WR_RESP);
	assign s_axi_bresp_o = bresp_r;
	assign s_axi_rvalid_o = (rd_st_r == RD_RESP);
	assign s_axi_rresp_o = rresp_r;
	assign s_axi_rdata_o = rdata_r;
	logic cpu_push, cpu_pop;
	assign cpu_push = wr_go && s_axi_wstrb_i[0] && (wr_idx == IDX_FIFO_DATA); // R1
	assign cpu_pop = rd_go && (word_idx(s_axi_araddr_i) == IDX_FIFO_DATA); // R1
	////////////////////////////////////////////////////////////////////////////
	// Endpoint FIFOs: shared memory, one region per endpoint
	logic mem_we;
	logic [AW-1:0] mem_waddr, mem_raddr;
	logic [7:0] mem_wdata, mem_rdata;
	logic [EP_W-1:0] pop_ep;
	logic sie_pop;
	assign sie_pop = sie_rd_i && !cpu_pop;
	assign pop_ep = cpu_pop ? selected_endpoint_r : sie_ep_i; // R11
	// CPU write wins over a simultaneous engine write
	assign mem_we = cpu_push || sie_wr_i;
	assign mem_waddr = cpu_push ?
		{selected_endpoint_r, wptr_r[selected_endpoint_r][DEPTH_LOG2-1:0]} :
		{sie_ep_i, wptr_r[sie_ep_i][DEPTH_LOG2-1:0]};
	assign mem_wdata = cpu_push ? wbyte : sie_byte_i;
	assign mem_raddr = {pop_ep, rptr_r[pop_ep][DEPTH_LOG2-1:0]};
	assign sie_byte_o = mem_rdata;
	ep_fifo_mem #(
		.DW(8),
		.AW(AW)
	) u_mem (
		.clk_i(clk_i),
		.we_i(mem_we),
		.waddr_i(mem_waddr),
		.wdata_i(mem_wdata),
		.raddr_i(mem_raddr),
		.rdata_o(mem_rdata)
	);
	logic push_full, pop_empty;
	logic [EP_W-1:0] push_ep;
	assign push_ep = cpu_push ? selected_endpoint_r : sie_ep_i;
	assign push_full = (wptr_r[push_ep] - rptr_r[push_ep]) == ptr_t'(1 << DEPTH_LOG2);
	assign pop_empty = wptr_r[pop_ep] == rptr_r[pop_ep];
	generate
		for (genvar g = 0; g < NUM_EP; g++) begin : g_ep
			ptr_t wptr_nxt, rptr_nxt;
			logic [6:0] cnt_nxt;
			always_comb begin
				wptr_nxt = wptr_r[g];
				rptr_nxt = rptr_r[g];
				cnt_nxt = rx_byte_total_r[g];
				if (mem_we && push_ep == EP_W'(g) && !push_full) begin
					wptr_nxt = wptr_r[g] + ptr_t'(1);
				end
				if ((cpu_pop || sie_pop) && pop_ep == EP_W'(g) && !pop_empty) begin
					rptr_nxt = rptr_r[g] + ptr_t'(1);
				end
				if (sie_pkt_start_i && sie_ep_i == EP_W'(g)) begin
					cnt_nxt = 7'h00; // R3
				end else if (sie_wr_i && !cpu_push && sie_ep_i == EP_W'(g)) begin
					cnt_nxt = rx_byte_total_r[g] + 7'h01; // R3
				end
				if (fifo_clear_r[g]) begin
					wptr_nxt = '0; // R5
					rptr_nxt = '0; // R5
					cnt_nxt = 7'h00; // R5
				end
			end
			always_ff @(posedge clk_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					wptr_r[g] <= '0;
					rptr_r[g] <= '0;
					rx_byte_total_r[g] <= 7'h00;
				end else begin
					wptr_r[g] <= wptr_nxt;
					rptr_r[g] <= rptr_nxt;
					rx_byte_total_r[g] <= cnt_nxt;
				end
			end
		end
	endgenerate
	////////////////////////////////////////////////////////////////////////////
	// Endpoint interrupt flags
	logic [NUM_EP-1:0] ep_event;
	assign ep_event = sie_in_done_i | sie_out_stored_i | sie_setup_rx_i | sie_stall_sent_i; // R10
	assign ep_irq_o = |irq_flag_r; // R12
	assign irq_o = |(status_r & mask_r);
	assign fifo_clear_o = fifo_clear_r;
	always_comb begin
		irq_allow_nxt = irq_allow_r;
		fifo_clear_nxt = fifo_clear_r;
		selected_endpoint_nxt = selected_endpoint_r;
		mask_nxt = mask_r;
		status_nxt = status_r;
		wr_st_nxt = wr_st_r;
		bresp_nxt = bresp_r;
		// Flags drop only when their enable is removed or on a bus reset
		irq_flag_nxt = usb_bus_reset_i ? '0 : ((irq_flag_r | ep_event) & irq_allow_r); // R7 R9
		case (wr_st_r)
			WR_IDLE: begin
				if (wr_go) begin
					wr_st_nxt = WR_RESP;
					bresp_nxt = RESP_OKAY;
					if (!s_axi_wstrb_i[0]) begin
						bresp_nxt = RESP_OKAY;
					end else if (wr_idx == IDX_IRQ_ENABLE) begin
						irq_allow_nxt = wbyte[NUM_EP-1:0]; // R9 R4
					end else if (wr_idx == IDX_FIFO_CLEAR) begin
						fifo_clear_nxt = wbyte[NUM_EP-1:0]; // R5 R4
					end else if (wr_idx == IDX_EP_SELECT) begin
						selected_endpoint_nxt = wbyte[EP_W-1:0]; // R11
					end else if (wr_idx == IDX_IRQ_MASK) begin
						mask_nxt = wbyte[ST_W-1:0];
					end else if (!(wr_idx inside {IDX_IRQ_FLAGS, IDX_FIFO_DATA, IDX_RX_COUNT, // R8
						IDX_IRQ_STATUS})) begin
						bresp_nxt = RESP_SLVERR;
					end
				end
			end
			WR_RESP: begin
				if (s_axi_bready_i) begin
					wr_st_nxt = WR_IDLE;
				end
			end
			default: wr_st_nxt = WR_IDLE;
		endcase
		if (rd_st_r == RD_WAIT && rd_idx_r == IDX_IRQ_STATUS) begin
			status_nxt = '0;
		end
		// Hardware sets win over the read clear
		if (|(ep_event & irq_allow_r)) begin
			status_nxt[ST_EP_EVENT] = 1'b1;
		end
		if (mem_we && push_full) begin
			status_nxt[ST_OVERFLOW] = 1'b1;
		end
		if ((cpu_pop || sie_pop) && pop_empty) begin
			status_nxt[ST_UNDERFLOW] = 1'b1;
		end
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			irq_allow_r <= RST_ENABLE[NUM_EP-1:0];
			fifo_clear_r <= RST_CLEAR[NUM_EP-1:0];
			irq_flag_r <= '0;
			selected_endpoint_r <= RST_SELECT;
			mask_r <= RST_MASK[ST_W-1:0];
			status_r <= '0;
			wr_st_r <= WR_IDLE;
			bresp_r <= RESP_OKAY;
		end else begin
			irq_allow_r <= irq_allow_nxt;
			fifo_clear_r <= fifo_clear_nxt;
			irq_flag_r <= irq_flag_nxt;
			selected_endpoint_r <= selected_endpoint_nxt;
			mask_r <= mask_nxt;
			status_r <= status_nxt;
			wr_st_r <= wr_st_nxt;
			bresp_r <= bresp_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Read path: one wait cycle lets the FIFO memory deliver its byte
	always_comb begin
		rd_st_nxt = rd_st_r;
		rd_idx_nxt = rd_idx_r;
		rresp_nxt = rresp_r;
		rdata_nxt = rdata_r;
		case (rd_st_r)
			RD_IDLE: begin
				if (rd_go) begin
					rd_idx_nxt = word_idx(s_axi_araddr_i);
					rd_st_nxt = RD_WAIT;
				end
			end
			RD_WAIT: begin
				rd_st_nxt = RD_RESP;
				rresp_nxt = RESP_OKAY;
				rdata_nxt = 32'h0000_0000; // R4
				if (rd_idx_r == IDX_FIFO_DATA) begin
					rdata_nxt[7:0] = mem_rdata; // R1 R2
				end else if (rd_idx_r == IDX_RX_COUNT) begin
					rdata_nxt[6:0] = rx_byte_total_r[selected_endpoint_r]; // R3 R11
				end else if (rd_idx_r == IDX_FIFO_CLEAR) begin
					rdata_nxt[NUM_EP-1:0] = fifo_clear_r;
				end else if (rd_idx_r == IDX_IRQ_FLAGS) begin
					rdata_nxt[NUM_EP-1:0] = irq_flag_r;
				end else if (rd_idx_r == IDX_IRQ_ENABLE) begin
					rdata_nxt[NUM_EP-1:0] = irq_allow_r;
				end else if (rd_idx_r == IDX_EP_SELECT) begin
					rdata_nxt[EP_W-1:0] = selected_endpoint_r;
				end else if (rd_idx_r == IDX_IRQ_STATUS) begin
					rdata_nxt[ST_W-1:0] = status_r;
				end else if (rd_idx_r == IDX_IRQ_MASK) begin
					rdata_nxt[ST_W-1:0] = mask_r;
				end else begin
					rresp_nxt = RESP_SLVERR;
				end
			end
			RD_RESP: begin
				if (s_axi_rready_i) begin
					rd_st_nxt = RD_IDLE;
				end
			end
			default: rd_st_nxt = RD_IDLE;
		endcase
	end
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_st_r <= RD_IDLE;
			rd_idx_r <= 8'h00;
			rresp_r <= RESP_OKAY;
			rdata_r <= 32'h0000_0000;
		end else begin
			rd_st_r <= rd_st_nxt;
			rd_idx_r <= rd_idx_nxt;
			rresp_r <= rresp_nxt;
			rdata_r <= rdata_nxt;
		end
	end
	////////////////////////////////////////////////////////////////////////////
	// Checks
	sequence s_event_allowed(int n);
		sie_in_done_i[n] && irq_allow_r[n];
	endsequence
	chk_flag_set: assert property ((|(ep_event & irq_allow_r) && !usb_bus_reset_i) // R7
		|=> |irq_flag_r) else $error("enabled event did not set a flag");
	chk_flag_blocked: assert property ((irq_allow_r == '0) |=> (irq_flag_r == '0)) // R9
		else $error("flag set while all enables clear");
	chk_in_done: assert property ((s_event_allowed(0) and !usb_bus_reset_i) // R10
		|=> irq_flag_r[0]) else $error("IN completion did not flag endpoint 0");
	chk_ep_irq_or: assert property (ep_irq_o == (irq_flag_r != '0)) // R12
		else $error("endpoint request differs from flag OR");
	chk_clear_hold: assert property (fifo_clear_r[0] ##1 fifo_clear_r[0] // R5
		|-> (wptr_r[0] == '0 && rptr_r[0] == '0)) else $error("cleared FIFO not empty");
	chk_rsvd_zero: assert property (s_axi_rvalid_o && rresp_r == RESP_OKAY // R4
		&& rd_idx_r != IDX_FIFO_DATA |-> s_axi_rdata_o[31:7] == '0)
		else $error("reserved bits read non-zero");
	chk_flags_ro: assert property (wr_go && wr_idx == IDX_IRQ_FLAGS && ep_event == '0 // R8
		&& irq_flag_r == '0 |=> irq_flag_r == '0) else $error("flag register changed by write");
	chk_count_rd: assert property (rd_st_r == RD_WAIT && rd_idx_r == IDX_RX_COUNT // R3
		|=> s_axi_rdata_o[6:0] == $past(rx_byte_total_r[selected_endpoint_r]))
		else $error("byte count read mismatch");
	chk_push_ptr: assert property (cpu_push && !push_full && !fifo_clear_r[5] // R1
		&& selected_endpoint_r == 3'h5 |=> wptr_r[5] == $past(wptr_r[5]) + ptr_t'(1))
		else $error("data port write did not push");
endmodule : usb_ep_regs

// file: verif/sie_host_model.sv
// Serial engine stand-in that fills, drains and signals the endpoint FIFOs
`timescale 1ns/1ps
module sie_host_model
	import usb_ep_pkg::*;
(
	// Clock
	input wire logic clk_i,
	// Status events
	output logic [NUM_EP-1:0] sie_in_done_o,
	output logic [NUM_EP-1:0] sie_out_stored_o,
	output logic [NUM_EP-1:0] sie_setup_rx_o,
	output logic [NUM_EP-1:0] sie_stall_sent_o,
	// FIFO traffic
	output logic sie_wr_o,
	output logic sie_rd_o,
	output logic sie_pkt_start_o,
	output logic [EP_W-1:0] sie_ep_o,
	output logic [7:0] sie_byte_o,
	input wire logic [7:0] sie_byte_i
);
	initial begin
		{sie_in_done_o, sie_out_stored_o, sie_setup_rx_o, sie_stall_sent_o} = '0;
		{sie_wr_o, sie_rd_o, sie_pkt_start_o} = '0;
		sie_ep_o = '0;
		sie_byte_o = 8'hA5;
	end
	////////////////////////////////////////////////////////////////////////////////
	// Marks the data PID of a new packet
	task automatic start(input logic [EP_W-1:0] e);
		@(posedge clk_i);
		sie_pkt_start_o <= 1'b1;
		sie_ep_o <= e;
		@(posedge clk_i);
		sie_pkt_start_o <= 1'b0;
	endtask : start
	task automatic push(input logic [EP_W-1:0] e, input logic [7:0] b);
		@(posedge clk_i);
		sie_wr_o <= 1'b1;
		sie_ep_o <= e;
		sie_byte_o <= b;
		@(posedge clk_i);
		sie_wr_o <= 1'b0;
		// Released data shows the inverse, never the last byte
		sie_byte_o <= ~b;
	endtask : push
	task automatic pop(input logic [EP_W-1:0] e, output logic [7:0] b);
		@(posedge clk_i);
		sie_rd_o <= 1'b1;
		sie_ep_o <= e;
		@(posedge clk_i);
		sie_rd_o <= 1'b0;
		#1;
		b = sie_byte_i;
	endtask : pop
	// Kinds: 0 IN done, 1 OUT stored, 2 SETUP received, 3 STALL sent
	task automatic event_pulse(input int k, input logic [EP_W-1:0] e);
		logic [NUM_EP-1:0] v;
		v = 7'h01 << e;
		@(posedge clk_i);
		case (k)
			0: sie_in_done_o <= v;
			1: sie_out_stored_o <= v;
			2: sie_setup_rx_o <= v;
			default: sie_stall_sent_o <= v;
		endcase
		@(posedge clk_i);
		{sie_in_done_o, sie_out_stored_o, sie_setup_rx_o, sie_stall_sent_o} <= '0;
	endtask : event_pulse
endmodule : sie_host_model

// file: verif/test_usb_endpoint_fifo_irq.sv
// Self-checking bench for the endpoint FIFO and interrupt register block
`timescale 1ns/1ps
module test_usb_endpoint_fifo_irq import usb_ep_pkg::*;;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic bus_rst = 1'b0;
	logic [11:0] awaddr = '0, araddr = '0;
	logic [31:0] wdata = '0;
	logic [3:0] wstrb = 4'h1;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, ep_irq, irq, sie_wr, pkt_st, sie_rd;
	logic [1:0] bresp, rresp, r, wresp;
	logic [31:0] rdata, d;
	logic [NUM_EP-1:0] in_done, out_st, setup_rx, stall_s, fclr;
	logic [EP_W-1:0] sie_ep;
	logic [7:0] byte_in, byte_out, b;
	logic [6:0] en, ex;
	logic [31:0] seed = 32'h3236E2F4;
	logic [7:0] q [NUM_EP][$];
	int n_fail = 0, checked = 0, cyc = 0, n;
	always #5 clk_i = ~clk_i;
	usb_ep_regs usb_ep_regs_inst (.clk_i(clk_i), .rst_n_i(rst_n_i), .usb_bus_reset_i(bus_rst),
		.s_axi_awaddr_i(awaddr), .s_axi_awvalid_i(awvalid), .s_axi_awready_o(awready),
		.s_axi_wdata_i(wdata), .s_axi_wstrb_i(wstrb), .s_axi_wvalid_i(wvalid),
		.s_axi_wready_o(wready), .s_axi_bresp_o(bresp), .s_axi_bvalid_o(bvalid),
		.s_axi_bready_i(bready), .s_axi_araddr_i(araddr), .s_axi_arvalid_i(arvalid),
		.s_axi_arready_o(arready), .s_axi_rdata_o(rdata), .s_axi_rresp_o(rresp),
		.s_axi_rvalid_o(rvalid), .s_axi_rready_i(rready), .sie_in_done_i(in_done),
		.sie_out_stored_i(out_st), .sie_setup_rx_i(setup_rx), .sie_stall_sent_i(stall_s),
		.sie_wr_i(sie_wr), .sie_ep_i(sie_ep), .sie_byte_i(byte_in), .sie_pkt_start_i(pkt_st),
		.sie_rd_i(sie_rd), .sie_byte_o(byte_out), .fifo_clear_o(fclr), .ep_irq_o(ep_irq),
		.irq_o(irq));
	sie_host_model sie_host_model_inst (.clk_i(clk_i), .sie_in_done_o(in_done),
		.sie_out_stored_o(out_st), .sie_setup_rx_o(setup_rx), .sie_stall_sent_o(stall_s),
		.sie_wr_o(sie_wr), .sie_rd_o(sie_rd), .sie_pkt_start_o(pkt_st), .sie_ep_o(sie_ep),
		.sie_byte_o(byte_in), .sie_byte_i(byte_out));
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h04C11DB7 : 32'h0);
		return seed;
	endfunction : rnd
	// Flag expected from one event on endpoint p
	function automatic logic [6:0] exp_flag(input logic [6:0] e, input int p);
		return e & (7'h01 << p);
	endfunction : exp_flag
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checked++;
		if (g !== e) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
			n_fail++;
		end
	endtask : chk
	task automatic wr(input logic [7:0] i, input logic [7:0] v);
		@(posedge clk_i);
		awaddr <= {2'b00, i, 2'b00};
		wdata <= {24'h0, v};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do @(posedge clk_i); while (!(awready && wready));
		awvalid <= 1'b0;
		wvalid <= 1'b0;
		do @(posedge clk_i); while (!bvalid);
		wresp = bresp;
		bready <= 1'b0;
		#1;
	endtask : wr
	task automatic rd(input logic [7:0] i, output logic [31:0] v, output logic [1:0] rs);
		@(posedge clk_i);
		araddr <= {2'b00, i, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge clk_i); while (!arready);
		arvalid <= 1'b0;
		do @(posedge clk_i); while (!rvalid);
		v = rdata;
		rs = rresp;
		rready <= 1'b0;
		#1;
	endtask : rd
	task automatic rdc(input string nm, input logic [7:0] i, input logic [31:0] e);
		rd(i, d, r);
		chk(nm, e, d);
		chk("read resp", RESP_OKAY, r);
	endtask : rdc
	task automatic final_report();
		$display("comparisons %0d mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : final_report
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_fail++;
			final_report();
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		rdc("enable", IDX_IRQ_ENABLE, RST_ENABLE);
		rdc("clear", IDX_FIFO_CLEAR, RST_CLEAR);
		rdc("flags", IDX_IRQ_FLAGS, 8'h00);
		rd(8'h01, d, r);
		chk("unmapped resp", RESP_SLVERR, r);
		wr(8'h01, 8'h00);
		chk("unmapped write resp", RESP_SLVERR, wresp);
		$display("test reset done");
		wr(IDX_FIFO_CLEAR, 8'hFF);
		rdc("clear set", IDX_FIFO_CLEAR, 8'h7F);
		chk("clear pins", 7'h7F, fclr);
		wr(IDX_FIFO_CLEAR, 8'h00);
		chk("clear pins", 7'h00, fclr);
		wr(IDX_EP_SELECT, 8'h02);
		sie_host_model_inst.start(3'h2);
		repeat (3) sie_host_model_inst.push(3'h2, 8'h3C);
		rdc("count", IDX_RX_COUNT, 8'h03);
		wr(IDX_FIFO_CLEAR, 8'h04);
		wr(IDX_FIFO_CLEAR, 8'h00);
		rdc("count after clear", IDX_RX_COUNT, 8'h00);
		$display("test fifo clear done");
		for (int e = 0; e < NUM_EP; e++) begin
			n = 1 + rnd() % 5;
			sie_host_model_inst.start(e[2:0]);
			repeat (n) begin
				b = rnd();
				sie_host_model_inst.push(e[2:0], b);
				q[e].push_back(b);
			end
		end
		for (int e = NUM_EP - 1; e >= 0; e--) begin
			wr(IDX_EP_SELECT, e[7:0]);
			rdc("count", IDX_RX_COUNT, q[e].size());
			while (q[e].size() > 0)
				rdc("data port", IDX_FIFO_DATA, q[e].pop_front());
		end
		$display("test packets done");
		wr(IDX_EP_SELECT, 8'h05);
		repeat (3) begin
			b = rnd();
			q[5].push_back(b);
			wr(IDX_FIFO_DATA, b);
		end
		repeat (3) begin
			sie_host_model_inst.pop(3'h5, b);
			chk("engine byte", q[5].pop_front(), b);
		end
		$display("test cpu fifo done");
		b = rnd();
		wr(IDX_IRQ_ENABLE, b);
		rdc("enable", IDX_IRQ_ENABLE, {25'h0, b[6:0]});
		wstrb <= 4'h0;
		wr(IDX_IRQ_ENABLE, ~b);
		wstrb <= 4'h1;
		rdc("enable no strobe", IDX_IRQ_ENABLE, {25'h0, b[6:0]});
		wr(IDX_IRQ_FLAGS, 8'hFF);
		chk("flags write resp", RESP_OKAY, wresp);
		rdc("flags write", IDX_IRQ_FLAGS, 8'h00);
		wr(IDX_IRQ_MASK, 8'h01);
		rd(IDX_IRQ_STATUS, d, r);
		for (int k = 0; k < 4; k++) begin
			en = (k == 0) ? 7'h7F : rnd();
			wr(IDX_IRQ_ENABLE, {1'b0, en});
			ex = '0;
			for (int e = 0; e < NUM_EP; e++) begin
				sie_host_model_inst.event_pulse(k, e[2:0]);
				ex |= exp_flag(en, e);
			end
			rdc("flags", IDX_IRQ_FLAGS, {25'h0, ex});
			chk("ep irq", |ex, ep_irq);
			chk("irq", |ex, irq);
			rdc("status", IDX_IRQ_STATUS, {31'h0, |ex});
			chk("irq after read", 1'b0, irq);
			@(posedge clk_i);
			bus_rst <= 1'b1;
			@(posedge clk_i);
			bus_rst <= 1'b0;
			rdc("flags bus reset", IDX_IRQ_FLAGS, 8'h00);
			chk("ep irq", 1'b0, ep_irq);
		end
		$display("test interrupts done");
		final_report();
	end
endmodule : test_usb_endpoint_fifo_irq
